// [dacs_pkg.sv]
// constants, field layout and state codes for the dual converter control block
// assumes clk_i is the conversion clock: one clk_i edge is one converter clock period
package dacs_pkg;
    // ****************************************
    // widths and configuration word layout
    // ****************************************
    localparam int DATA_W = 12;
    localparam int TRIM_W = 10;
    localparam int CFG_W = 12;
    localparam int CFG_CH_HI_BIT = 11;
    localparam int CFG_CH_LO_BIT = 10;
    localparam int CFG_ADDR_LSB = 0;
    localparam int CFG_ADDR_W = 3;
    localparam logic [CFG_ADDR_W-1:0] ADDR_TRIM = 3'h3;
    localparam logic [CFG_ADDR_W-1:0] ADDR_SWRST = 3'h7;
    localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
    localparam logic [TRIM_W-1:0] TRIM_RST = 10'h3FF;
    localparam logic [DATA_W-1:0] SAR_MSB = 12'h800;
    localparam logic [DATA_W+1:0] DIFF_OFFSET = 14'h1000;

    // ****************************************
    // timing, in ps and in converter clock periods
    // ****************************************
    localparam int CLK_PS = 20000;
    localparam int CONV_CLK_MIN_PS = 31250;
    localparam int T_CONV_MIN_PS = 406250;
    localparam int T_ACQ_MIN_PS = 62500;
    localparam int CONV_PERIODS = (T_CONV_MIN_PS + CONV_CLK_MIN_PS - 1) / CONV_CLK_MIN_PS;
    localparam int SAR_STEPS = CONV_PERIODS - 1;
    localparam int PRE_CYC = 1;
    localparam int ACQ_CYC = (T_ACQ_MIN_PS + CONV_CLK_MIN_PS - 1) / CONV_CLK_MIN_PS;
    localparam logic [3:0] SAR_STEPS_C = 4'(SAR_STEPS);
    localparam logic [3:0] ACQ_CYC_C = 4'(ACQ_CYC);
    localparam logic [3:0] CFG_BITS_C = 4'(CFG_W);

    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [1:0] {
        CH_P0 = 2'h0,
        CH_P1_INV = 2'h1,
        CH_P1_NONINV = 2'h2,
        CH_P1 = 2'h3
    } dacs_chan_t;

    typedef enum logic [1:0] {
        ST_ACQ = 2'h0,
        ST_HOLD = 2'h1,
        ST_CONV = 2'h3,
        ST_PRE = 2'h2
    } dacs_state_t;
endpackage : dacs_pkg

// [dacs_sar_if.sv]
// link between the sequencer and one successive-approximation converter
// assumes both ends share clk_i
`timescale 1ns/1ns
`default_nettype none
interface dacs_sar_if;
    import dacs_pkg::*;
    logic start;
    logic step;
    logic [DATA_W-1:0] target;
    logic [DATA_W-1:0] result;
    modport ctl (output start, output step, output target, input result);
    modport sar (input start, input step, input target, output result);
endinterface : dacs_sar_if
`default_nettype wire

// [dacs_sar.sv]
// one successive-approximation converter, one bit decided per step
// assumes the sequencer gives exactly SAR_STEPS steps after each start
`timescale 1ns/1ns
`default_nettype none
module dacs_sar (
    input wire logic clk_i,
    input wire logic arst_n_i,
    dacs_sar_if.sar sar
);
    import dacs_pkg::*;

    logic [DATA_W-1:0] res_r;
    logic [DATA_W-1:0] mask_r;
    logic [DATA_W-1:0] trial;

    assign trial = res_r | mask_r;
    assign sar.result = res_r;

    // ****************************************
    // bit decisions
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res_r <= '0;
            mask_r <= '0;
        end else if (sar.start) begin
            res_r <= '0;
            mask_r <= SAR_MSB;
        end else if (sar.step && mask_r != '0) begin
            if (sar.target >= trial) begin
                res_r <= trial;
            end
            mask_r <= mask_r >> 1;
        end
    end
endmodule : dacs_sar
`default_nettype wire

// [dacs_ctrl.sv]
// dual simultaneous-sampling converter control: channel mux, sample sequence, serial config
// assumes inputs are synchronous to clk_i; analog pins arrive as 12-bit levels
`timescale 1ns/1ns
`default_nettype none
module dacs_ctrl (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic conversion_trigger_i,
    input wire logic rd_i,
    input wire logic serial_cfg_input_i,
    input wire logic [dacs_pkg::DATA_W-1:0] pair0_noninv_in_a_i,
    input wire logic [dacs_pkg::DATA_W-1:0] pair0_inv_in_a_i,
    input wire logic [dacs_pkg::DATA_W-1:0] pair1_noninv_in_a_i,
    input wire logic [dacs_pkg::DATA_W-1:0] pair1_inv_in_a_i,
    input wire logic [dacs_pkg::DATA_W-1:0] pair0_noninv_in_b_i,
    input wire logic [dacs_pkg::DATA_W-1:0] pair0_inv_in_b_i,
    input wire logic [dacs_pkg::DATA_W-1:0] pair1_noninv_in_b_i,
    input wire logic [dacs_pkg::DATA_W-1:0] pair1_inv_in_b_i,
    output logic busy_o,
    output logic acq_ready_o,
    output logic chan_sel_hi_o,
    output logic chan_sel_lo_o,
    output logic [dacs_pkg::DATA_W-1:0] result_a_o,
    output logic [dacs_pkg::DATA_W-1:0] result_b_o,
    output logic result_valid_o,
    output logic [dacs_pkg::TRIM_W-1:0] reference_output_o
);
    import dacs_pkg::*;

    // ****************************************
    // input multiplexer
    // ****************************************
    // offset-binary code of (plus - minus), full scale over 12 bits
    function automatic logic [DATA_W-1:0] mux_code(
        input logic [1:0] ch,
        input logic [DATA_W-1:0] p0p,
        input logic [DATA_W-1:0] p0n,
        input logic [DATA_W-1:0] p1p,
        input logic [DATA_W-1:0] p1n
    );
        logic [DATA_W-1:0] plus;
        logic [DATA_W-1:0] minus;
        logic [DATA_W+1:0] sum;
        plus = p0p;
        minus = p0n;
        unique case (dacs_chan_t'(ch))
            CH_P0: begin
                plus = p0p;
                minus = p0n;
            end
            CH_P1_INV: begin
                plus = p1n;
                minus = p0n;
            end
            CH_P1_NONINV: begin
                plus = p1p;
                minus = p0n;
            end
            CH_P1: begin
                plus = p1p;
                minus = p1n;
            end
        endcase
        sum = {2'b00, plus} + DIFF_OFFSET - {2'b00, minus};
        return sum[DATA_W:1];
    endfunction : mux_code

    // ****************************************
    // serial configuration port
    // ****************************************
    logic [CFG_W-1:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic word_done_r;
    logic [1:0] chan_r;
    logic [TRIM_W-1:0] trim_r;
    logic trim_pend_r;
    logic [CFG_ADDR_W-1:0] word_addr;

    assign word_addr = shift_r[CFG_ADDR_LSB +: CFG_ADDR_W];

    // msb-first word on the data pin
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_r <= CFG_RST;
            bit_cnt_r <= '0;
            word_done_r <= 1'b0;
        end else begin
            word_done_r <= 1'b0;
            if (bit_cnt_r != '0) begin
                shift_r <= {shift_r[CFG_W-2:0], serial_cfg_input_i};
                bit_cnt_r <= bit_cnt_r - 4'h1;
                word_done_r <= (bit_cnt_r == 4'h1);
            end else if (rd_i) begin
                shift_r <= {shift_r[CFG_W-2:0], serial_cfg_input_i};
                bit_cnt_r <= CFG_BITS_C - 4'h1;
            end
        end
    end

    // one channel selection for both converters
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chan_r <= CFG_RST[CFG_CH_HI_BIT:CFG_CH_LO_BIT];
        end else if (word_done_r && !trim_pend_r) begin
            if (word_addr == ADDR_SWRST) begin
                chan_r <= CFG_RST[CFG_CH_HI_BIT:CFG_CH_LO_BIT];
            end else begin
                chan_r <= shift_r[CFG_CH_HI_BIT:CFG_CH_LO_BIT];
            end
        end
    end

    // trim word follows a trim command word
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trim_r <= TRIM_RST;
            trim_pend_r <= 1'b0;
        end else if (word_done_r) begin
            if (trim_pend_r) begin
                trim_r <= shift_r[TRIM_W-1:0];
                trim_pend_r <= 1'b0;
            end else if (word_addr == ADDR_SWRST) begin
                trim_r <= TRIM_RST;
            end else begin
                trim_pend_r <= (word_addr == ADDR_TRIM);
            end
        end
    end

    assign reference_output_o = trim_r;

    // ****************************************
    // sample / hold / convert sequence
    // ****************************************
    dacs_state_t state_r;
    logic trig_d_r;
    logic [3:0] step_cnt_r;
    logic [3:0] acq_cnt_r;
    logic [1:0] chan_hold_r;
    logic [DATA_W-1:0] target_a_r;
    logic [DATA_W-1:0] target_b_r;
    logic accept;
    logic acq_ok;

    assign acq_ok = (state_r == ST_ACQ) && (acq_cnt_r >= ACQ_CYC_C);
    assign acq_ready_o = acq_ok;
    // triggers during busy or too early in acquisition are dropped
    // rise takes the hold
    assign accept = conversion_trigger_i && !trig_d_r && acq_ok;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= conversion_trigger_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_ACQ;
        end else begin
            unique case (state_r)
                ST_ACQ: begin
                    if (accept) begin
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: state_r <= ST_CONV;
                ST_CONV: begin
                    if (step_cnt_r == SAR_STEPS_C - 4'h1) begin
                        state_r <= ST_PRE;
                    end
                end
                ST_PRE: state_r <= ST_ACQ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            step_cnt_r <= '0;
        end else if (state_r == ST_CONV) begin
            step_cnt_r <= step_cnt_r + 4'h1;
        end else begin
            step_cnt_r <= '0;
        end
    end

    // count starts at the precharge edge
    // so ready lands on the sixteenth clock and full rate stays reachable
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acq_cnt_r <= '0;
        end else if (state_r == ST_HOLD || state_r == ST_CONV) begin
            acq_cnt_r <= '0;
        end else if (acq_cnt_r < ACQ_CYC_C) begin
            acq_cnt_r <= acq_cnt_r + 4'h1;
        end
    end

    // both inputs held on one edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chan_hold_r <= CFG_RST[CFG_CH_HI_BIT:CFG_CH_LO_BIT];
            target_a_r <= '0;
            target_b_r <= '0;
        end else if (accept) begin
            chan_hold_r <= chan_r;
            target_a_r <= mux_code(chan_r, pair0_noninv_in_a_i, pair0_inv_in_a_i,
                                   pair1_noninv_in_a_i, pair1_inv_in_a_i);
            target_b_r <= mux_code(chan_r, pair0_noninv_in_b_i, pair0_inv_in_b_i,
                                   pair1_noninv_in_b_i, pair1_inv_in_b_i);
        end
    end

    assign chan_sel_hi_o = chan_hold_r[1];
    assign chan_sel_lo_o = chan_hold_r[0];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= accept || state_r == ST_HOLD ||
                      (state_r == ST_CONV && step_cnt_r != SAR_STEPS_C - 4'h1);
        end
    end

    // ****************************************
    // converters and results
    // ****************************************
    dacs_sar_if sar_a_if ();
    dacs_sar_if sar_b_if ();

    assign sar_a_if.start = (state_r == ST_HOLD);
    assign sar_b_if.start = (state_r == ST_HOLD);
    assign sar_a_if.step = (state_r == ST_CONV);
    assign sar_b_if.step = (state_r == ST_CONV);
    assign sar_a_if.target = target_a_r;
    assign sar_b_if.target = target_b_r;

    dacs_sar u_sar_a (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .sar(sar_a_if.sar)
    );

    dacs_sar u_sar_b (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .sar(sar_b_if.sar)
    );

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_a_o <= '0;
            result_b_o <= '0;
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= (state_r == ST_PRE);
            if (state_r == ST_PRE) begin
                result_a_o <= sar_a_if.result;
                result_b_o <= sar_b_if.result;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_busy_run;
        busy_o [*8] ##1 busy_o [*5] ##1 !busy_o;
    endsequence
    sequence s_hold_conv;
        state_r == ST_HOLD ##1 state_r == ST_CONV;
    endsequence

    property p_busy_len;
        $rose(busy_o) |-> s_busy_run;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy not 13 cycles");

    property p_start;
        accept |=> s_hold_conv ##0 busy_o;
    endproperty
    a_start: assert property (p_start) else $error("hold or conversion start late");

    property p_busy_rise;
        accept |=> busy_o;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy missing at hold");

    property p_acq_gap;
        $fell(busy_o) |-> (!accept && !acq_ready_o) [*2] ##1 acq_ready_o;
    endproperty
    a_acq_gap: assert property (p_acq_gap) else $error("sample cycle too short");

    property p_cycle16;
        accept |-> ##16 acq_ready_o;
    endproperty
    a_cycle16: assert property (p_cycle16) else $error("not ready after 16 clocks");

    property p_pair;
        state_r == ST_PRE |-> sar_a_if.result == target_a_r && sar_b_if.result == target_b_r;
    endproperty
    a_pair: assert property (p_pair) else $error("paired conversion wrong");

    property p_mux2;
        accept && chan_r == 2'h3 |=> target_a_r == mux_code(2'h3, '0, '0,
            $past(pair1_noninv_in_a_i), $past(pair1_inv_in_a_i));
    endproperty
    a_mux2: assert property (p_mux2) else $error("2:1 pair 1 misrouted");

    property p_mux3;
        accept && chan_r == 2'h1 |=> target_b_r == mux_code(2'h3, '0, '0,
            $past(pair1_inv_in_b_i), $past(pair0_inv_in_b_i));
    endproperty
    a_mux3: assert property (p_mux3) else $error("3:1 code 01 misrouted");

    property p_same_chan;
        accept |=> chan_hold_r == $past(chan_r) && {chan_sel_hi_o, chan_sel_lo_o} == chan_hold_r;
    endproperty
    a_same_chan: assert property (p_same_chan) else $error("channel not shared");

    property p_keep;
        state_r != ST_ACQ |=> $stable(chan_hold_r);
    endproperty
    a_keep: assert property (p_keep) else $error("channel changed mid conversion");

    property p_trim;
        word_done_r && trim_pend_r |=> reference_output_o == $past(shift_r[TRIM_W-1:0]);
    endproperty
    a_trim: assert property (p_trim) else $error("trim not written");

    property p_cfg;
        word_done_r && !trim_pend_r && word_addr != ADDR_SWRST
            |=> chan_r == $past(shift_r[CFG_CH_HI_BIT:CFG_CH_LO_BIT]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("channel word not taken");
endmodule : dacs_ctrl
`default_nettype wire

// [dacs_host.sv]
// host model for the dual converter control block: trigger and serial words
// assumes busy_i rises one clock after the device accepts a trigger
`timescale 1ns/1ns
`default_nettype none
module dacs_host (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic busy_i,
    output logic conversion_trigger_o,
    output logic rd_o,
    output logic serial_cfg_input_o
);
    logic in_word_r;
    logic bit_r;
    logic idle_r;

    // ****************************************
    // data line
    // ****************************************
    // idle line toggles so a stale bit never passes for data
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idle_r <= 1'b0;
        end else begin
            idle_r <= ~idle_r;
        end
    end
    assign serial_cfg_input_o = in_word_r ? bit_r : idle_r;

    initial begin
        in_word_r = 1'b0;
        bit_r = 1'b0;
        rd_o = 1'b0;
        conversion_trigger_o = 1'b0;
    end

    // ****************************************
    // requests
    // ****************************************
    // whole 12-bit word, msb first
    task automatic send_word(input logic [11:0] w);
        for (int i = 11; i >= 0; i--) begin
            @(posedge clk_i);
            in_word_r <= 1'b1;
            rd_o <= (i == 11);
            bit_r <= w[i];
        end
        @(posedge clk_i);
        in_word_r <= 1'b0;
        rd_o <= 1'b0;
    endtask : send_word

    task automatic trigger();
        logic done;
        logic prev;
        done = 1'b0;
        while (!done) begin
            @(posedge clk_i);
            conversion_trigger_o <= 1'b1;
            // busy before the sampled rise, so a fresh rise of busy marks the accept
            #1;
            prev = busy_i;
            @(posedge clk_i);
            conversion_trigger_o <= 1'b0;
            #1;
            done = busy_i && !prev;
        end
    endtask : trigger

    task automatic pulse();
        @(posedge clk_i);
        conversion_trigger_o <= 1'b1;
        @(posedge clk_i);
        conversion_trigger_o <= 1'b0;
    endtask : pulse
endmodule : dacs_host
`default_nettype wire

// [tb_dual_adc_channel_select.sv]
// self-checking bench for the dual converter control block
// assumes dacs_host drives trigger and serial pins; results checked from a queue
`timescale 1ns/1ns
`default_nettype none
module tb_dual_adc_channel_select;
    import dacs_pkg::*;
    logic clk_i;
    logic arst_n_i;
    logic trig;
    logic rd;
    logic serial_cfg_input;
    logic [DATA_W-1:0] ain [8];
    logic busy_o;
    logic acq_ready_o;
    logic ch_hi;
    logic ch_lo;
    logic valid;
    logic [DATA_W-1:0] res_a;
    logic [DATA_W-1:0] res_b;
    logic [TRIM_W-1:0] refv;
    integer seed = 32'hdb4f;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int since = 0;
    int bcnt = 0;
    int last_acc = 0;
    int prev_acc = 0;
    logic busy_d = 1'b0;
    logic [1:0] cur_code = 2'h0;
    logic [25:0] e;
    logic [25:0] exp_q [$];
    logic [TRIM_W-1:0] tv;

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= cyc + 1;

    dacs_ctrl i_dacs_ctrl (.clk_i(clk_i), .arst_n_i(arst_n_i), .conversion_trigger_i(trig), .rd_i(rd),
        .serial_cfg_input_i(serial_cfg_input), .pair0_noninv_in_a_i(ain[0]), .pair0_inv_in_a_i(ain[1]),
        .pair1_noninv_in_a_i(ain[2]), .pair1_inv_in_a_i(ain[3]), .pair0_noninv_in_b_i(ain[4]),
        .pair0_inv_in_b_i(ain[5]), .pair1_noninv_in_b_i(ain[6]), .pair1_inv_in_b_i(ain[7]),
        .busy_o(busy_o), .acq_ready_o(acq_ready_o), .chan_sel_hi_o(ch_hi), .chan_sel_lo_o(ch_lo),
        .result_a_o(res_a), .result_b_o(res_b), .result_valid_o(valid), .reference_output_o(refv));
    dacs_host i_dacs_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .busy_i(busy_o),
        .conversion_trigger_o(trig), .rd_o(rd), .serial_cfg_input_o(serial_cfg_input));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_checks++;
        if (seen !== expd) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    function automatic logic [11:0] expv(input logic [1:0] c, input logic [11:0] p0p, p0n, p1p, p1n);
        logic [13:0] d;
        d = {2'h0, (c == 2'h0) ? p0p : (c == 2'h1) ? p1n : p1p} - {2'h0, (c == 2'h3) ? p1n : p0n} + 14'h1000;
        return d[12:1];
    endfunction : expv

    task automatic rand_in();
        for (int i = 0; i < 8; i++) ain[i] <= 12'($random(seed));
    endtask : rand_in

    task automatic convert();
        @(posedge clk_i);
        exp_q.push_back({cur_code, expv(cur_code, ain[0], ain[1], ain[2], ain[3]),
            expv(cur_code, ain[4], ain[5], ain[6], ain[7])});
        i_dacs_host.trigger();
        check(acq_ready_o, 1'b0);
        prev_acc = last_acc;
        last_acc = cyc;
        // inputs move once held, conversion must not see it
        @(posedge clk_i);
        rand_in();
    endtask : convert

    task automatic set_code(input logic [1:0] c);
        i_dacs_host.send_word({c, 10'h0F0});
        cur_code = c;
    endtask : set_code

    // ****************************************
    // result watcher
    // ****************************************
    // outputs read mid cycle, clear of the launching edge
    always @(negedge clk_i) begin
        if (busy_o && !busy_d) since = 0;
        else since = since + 1;
        if (busy_o) begin
            bcnt = bcnt + 1;
        end else if (bcnt != 0) begin
            check(bcnt, 13);
            bcnt = 0;
        end
        busy_d = busy_o;
        if (valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(valid, 1'b0);
            end else begin
                e = exp_q.pop_front();
                check({ch_hi, ch_lo}, e[25:24]);
                check(res_a, e[23:12]);
                check(res_b, e[11:0]);
                check(since, 14);
            end
        end
    end

    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        arst_n_i = 1'b0;
        for (int i = 0; i < 8; i++) ain[i] = 12'h000;
        repeat (4) @(posedge clk_i);
        #1;
        check({busy_o, valid, ch_hi, ch_lo, acq_ready_o}, 5'h00);
        check(refv, TRIM_RST);
        check({res_a, res_b}, 24'h000000);
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        rand_in();
        $display("test reset done");
        // no word sent keeps code 00
        convert();
        $display("test legacy default done");
        @(posedge clk_i);
        ain <= '{12'hFFF, 12'h000, 12'h000, 12'hFFF, 12'h000, 12'hFFF, 12'hFFF, 12'h000};
        foreach (ain[k]) begin
            if (k < 4) begin
                set_code(2'(k ^ 2'h3));
                convert();
            end
        end
        $display("test channel codes done");
        for (int i = 0; i < 3; i++) begin
            convert();
            // next accept no sooner than sixteen clocks
            if (i > 0) check(32'((last_acc - prev_acc) >= 16 && (last_acc - prev_acc) <= 18), 32'h1);
        end
        $display("test back to back done");
        // write lands mid conversion, extra rise while busy is dropped
        fork
            begin
                convert();
                i_dacs_host.pulse();
            end
            begin
                // word starts as the previous conversion ends, lands in the next one
                @(negedge busy_o);
                i_dacs_host.send_word({~cur_code, 10'h0F0});
            end
        join
        cur_code = ~cur_code;
        convert();
        $display("test channel change done");
        i_dacs_host.send_word({cur_code, 10'h003});
        tv = 10'($random(seed));
        i_dacs_host.send_word({2'($random(seed)), tv});
        repeat (2) @(posedge clk_i);
        check(refv, tv);
        convert();
        i_dacs_host.send_word({2'h3, 10'h007});
        cur_code = 2'h0;
        repeat (2) @(posedge clk_i);
        check(refv, TRIM_RST);
        convert();
        $display("test trim and soft reset done");
        repeat (20) @(posedge clk_i);
        check(exp_q.size(), 0);
        print_verdict();
    end
endmodule : tb_dual_adc_channel_select
`default_nettype wire
